// file: rccfg_chk.sv
// Port checker for the run clock configuration register block
`timescale 1ns/10ps
module rccfg_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              pll_power_down,
  input wire logic              pll_bypass,
  input wire logic              main_osc_disable,
  input wire logic              internal_osc_disable,
  input wire logic [2:0]        osc_source,
  input wire logic [5:0]        system_divisor
);
  logic ovr;
  wire  acc_w  = psel && penable && pready && pwrite;
  wire  wr_run = acc_w && paddr == 12'h060 && !ovr;
  wire  wr_ext = acc_w && paddr == 12'h070 && pstrb[3];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Run-register writes steer divisor, power-down, bypass and source only while the override is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovr <= 1'h0;
    else if (wr_ext)
      ovr <= pwdata[31];
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  ready_pulse_a: assert property (s_setup |=> pready ##1 !pready)
    else $error("answer is not a single ready cycle");
  bad_addr_a: assert property (s_setup ##0 paddr == 12'h100 |=> pslverr && pready)
    else $error("unmapped access not refused");
  pll_power_down_a: assert property (wr_run && pstrb[1] |=> pll_power_down == $past(pwdata[13]))
    else $error("power-down output differs from written bit");
  bypass_a: assert property (wr_run && pstrb[1] |=> pll_bypass == $past(pwdata[11]))
    else $error("bypass output differs from written bit");
  src_sel_a: assert property (wr_run && pstrb[0] |=> osc_source == {1'h0, $past(pwdata[5:4])})
    else $error("source select differs from written field");
  internal_oscillator_dis_a: assert property (wr_run && pstrb[0] |=> internal_osc_disable == $past(pwdata[1]))
    else $error("internal oscillator disable wrong");
  main_oscillator_dis_a: assert property (wr_run && pstrb[0] |=> main_osc_disable == $past(pwdata[0]))
    else $error("main oscillator disable wrong");
  ovr_div_a: assert property (wr_ext && pstrb[2] && pwdata[31] |=> system_divisor == $past(pwdata[28:23]))
    else $error("override divisor not used");
endmodule : rccfg_chk

// file: rccfg_defines.svh
// Register offsets, field positions, reset values and PLL target and reset figures
`ifndef RCCFG_DEFINES_SVH
`define RCCFG_DEFINES_SVH
`define RCCFG_OFF_RUN        12'h060
`define RCCFG_OFF_EXT        12'h070
`define RCCFG_OFF_PLL        12'h064
`define RCCFG_RUN_RESET      32'h07803AD1
`define RCCFG_EXT_RESET      32'h07802810
`define RCCFG_RUN_WMASK      32'h0FC02BF3
`define RCCFG_RUN_FIXED1     32'h00001000
`define RCCFG_EXT_WMASK      32'h9F802870
`define RCCFG_MAIN_OSC_OFF   0
`define RCCFG_INT_OSC_OFF    1
`define RCCFG_OSCSRC_LO      4
`define RCCFG_OSCSRC_HI      5
`define RCCFG_OSCSRC2_HI     6
`define RCCFG_CRYSTAL_LO     6
`define RCCFG_CRYSTAL_HI     9
`define RCCFG_BIT_BYPASS     11
`define RCCFG_BIT_PLL_DOWN   13
`define RCCFG_BIT_USESYSDIV  22
`define RCCFG_DIVISOR_LO     23
`define RCCFG_DIVISOR_HI     26
`define RCCFG_EXT_DIV_HI     28
`define RCCFG_BIT_OVERRIDE   31
`define RCCFG_PLL_TARGET_MHZ 400
`define RCCFG_PLL_F_RESET    9'h0C8
`define RCCFG_PLL_R_RESET    5'h02
`endif

// file: rccfg_pkg.sv
// Types shared by the clock source configuration block
package rccfg_pkg;
  typedef enum logic [1:0] {
    RCCFG_SRC_MAIN,
    RCCFG_SRC_INT,
    RCCFG_SRC_INT_DIV4,
    RCCFG_SRC_LOW_30K
  } rccfg_src_t;
  typedef enum logic [1:0] {
    RCCFG_IDLE,
    RCCFG_ACCESS
  } rccfg_bus_state_t;
endpackage : rccfg_pkg

// file: rccfg_pll_lookup.sv
// Crystal codes 4 to F to PLL feedback and reference settings for a 400 MHz output, zero settings for codes 0 to 3
`timescale 1ns/10ps
module rccfg_pll_lookup #(
  parameter int FW = 9,
  parameter int RW = 5
) (
  input  wire logic [3:0]    crystal_frequency_code,
  output logic      [FW-1:0] pll_f,
  output logic      [RW-1:0] pll_r
);
  // F and R chosen with the crystal in kHz so that crystal*F/(R+1) nears the target
  always_comb begin
    pll_f = 9'h000;
    pll_r = 5'h00;
    case (crystal_frequency_code)
      4'h4:    begin pll_f = 9'h1BF; pll_r = 5'h03; end
      4'h5:    begin pll_f = 9'h1B2; pll_r = 5'h03; end
      4'h6:    begin pll_f = 9'h064; pll_r = 5'h00; end
      4'h7:    begin pll_f = 9'h186; pll_r = 5'h03; end
      4'h8:    begin pll_f = 9'h145; pll_r = 5'h03; end
      4'h9:    begin pll_f = 9'h050; pll_r = 5'h00; end
      4'hA:    begin pll_f = 9'h138; pll_r = 5'h03; end
      4'hB:    begin pll_f = 9'h0C8; pll_r = 5'h02; end
      4'hC:    begin pll_f = 9'h104; pll_r = 5'h03; end
      4'hD:    begin pll_f = 9'h0D9; pll_r = 5'h03; end
      4'hE:    begin pll_f = 9'h032; pll_r = 5'h00; end
      4'hF:    begin pll_f = 9'h0C3; pll_r = 5'h03; end
      default: begin pll_f = 9'h000; pll_r = 5'h00; end
    endcase
  end
endmodule : rccfg_pll_lookup

// file: rccfg_top.sv
// Run-mode clock source configuration register with APB slave
`timescale 1ns/10ps
`include "rccfg_defines.svh"
module rccfg_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   pll_power_down,
  output logic                   pll_bypass,
  output logic                   main_osc_disable,
  output logic                   internal_osc_disable,
  output logic      [2:0]        osc_source,
  output logic      [5:0]        system_divisor,
  output logic                   use_system_divider,
  output logic      [8:0]        pll_f,
  output logic      [4:0]        pll_r
);
  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [31:0] run_clock_configuration;
  logic [31:0] extended_clock_configuration;
  logic [31:0] next_run;
  logic [31:0] next_ext;
  logic [31:0] strobe_mask;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        access;
  logic        hit_run;
  logic        hit_ext;
  logic        hit_pll;
  logic [8:0]  lut_f;
  logic [4:0]  lut_r;
  logic        extended_override_enable;
  rccfg_pkg::rccfg_bus_state_t bus_state;
  localparam logic [31:0] RUN_RST = `RCCFG_RUN_RESET;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign hit_run = (paddr == ADDR_W'(`RCCFG_OFF_RUN));
  assign hit_ext = (paddr == ADDR_W'(`RCCFG_OFF_EXT));
  assign hit_pll = (paddr == ADDR_W'(`RCCFG_OFF_PLL));
  assign extended_override_enable = next_ext[`RCCFG_BIT_OVERRIDE];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strobe_mask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Writable bits merge in, reserved bits keep their fixed values
  // A write lands at the edge that closes its access phase
  always_comb begin
    next_run = run_clock_configuration;
    next_ext = extended_clock_configuration;
    if (access && pwrite && hit_run) begin
      next_run = (run_clock_configuration & ~(`RCCFG_RUN_WMASK & strobe_mask))
               | (pwdata & `RCCFG_RUN_WMASK & strobe_mask)
               | `RCCFG_RUN_FIXED1;
    end
    if (access && pwrite && hit_ext) begin
      next_ext = (extended_clock_configuration & ~(`RCCFG_EXT_WMASK & strobe_mask))
               | (pwdata & `RCCFG_EXT_WMASK & strobe_mask);
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (hit_run) begin
      next_rdata = run_clock_configuration;
    end else if (hit_ext) begin
      next_rdata = extended_clock_configuration;
    end else if (hit_pll) begin
      next_rdata = {18'h00000, lut_f, lut_r};
    end else begin
      next_err = 1'b1;
    end
    if (pwrite) begin
      next_rdata = 32'h00000000;
      next_err   = next_err || hit_pll;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_clock_configuration <= `RCCFG_RUN_RESET;
    end else begin
      run_clock_configuration <= next_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_clock_configuration <= `RCCFG_EXT_RESET;
    end else begin
      extended_clock_configuration <= next_ext;
    end
  end

  // --------------------------------------------------------------------
  // APB answer: one wait-free access phase after setup
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= rccfg_pkg::RCCFG_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      case (bus_state)
        rccfg_pkg::RCCFG_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (setup) begin
            bus_state <= rccfg_pkg::RCCFG_ACCESS;
            pready    <= 1'b1;
            pslverr   <= next_err;
            prdata    <= next_rdata;
          end
        end
        rccfg_pkg::RCCFG_ACCESS: begin
          bus_state <= rccfg_pkg::RCCFG_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          bus_state <= rccfg_pkg::RCCFG_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // PLL settings
  // --------------------------------------------------------------------
  rccfg_pll_lookup #(
    .FW (9),
    .RW (5)
  ) u_lookup (
    .crystal_frequency_code (next_run[`RCCFG_CRYSTAL_HI:`RCCFG_CRYSTAL_LO]),
    .pll_f                  (lut_f),
    .pll_r                  (lut_r)
  );

  // --------------------------------------------------------------------
  // Clock control outputs, registered from the next register value
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_disable     <= RUN_RST[`RCCFG_MAIN_OSC_OFF];
      internal_osc_disable <= RUN_RST[`RCCFG_INT_OSC_OFF];
      use_system_divider   <= RUN_RST[`RCCFG_BIT_USESYSDIV];
    end else begin
      main_osc_disable     <= next_run[`RCCFG_MAIN_OSC_OFF];
      internal_osc_disable <= next_run[`RCCFG_INT_OSC_OFF];
      use_system_divider   <= next_run[`RCCFG_BIT_USESYSDIV];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_f <= `RCCFG_PLL_F_RESET;
      pll_r <= `RCCFG_PLL_R_RESET;
    end else begin
      pll_f <= lut_f;
      pll_r <= lut_r;
    end
  end

  // Override steers divisor, power-down, bypass and source as one group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_power_down <= RUN_RST[`RCCFG_BIT_PLL_DOWN];
      pll_bypass     <= RUN_RST[`RCCFG_BIT_BYPASS];
      osc_source     <= {1'h0, RUN_RST[`RCCFG_OSCSRC_HI:`RCCFG_OSCSRC_LO]};
      system_divisor <= {2'h0, RUN_RST[`RCCFG_DIVISOR_HI:`RCCFG_DIVISOR_LO]};
    end else if (extended_override_enable) begin
      system_divisor <= next_ext[`RCCFG_EXT_DIV_HI:`RCCFG_DIVISOR_LO];
      pll_power_down <= next_ext[`RCCFG_BIT_PLL_DOWN];
      pll_bypass     <= next_ext[`RCCFG_BIT_BYPASS];
      osc_source     <= next_ext[`RCCFG_OSCSRC2_HI:`RCCFG_OSCSRC_LO];
    end else begin
      system_divisor <= {2'h0, next_run[`RCCFG_DIVISOR_HI:`RCCFG_DIVISOR_LO]};
      pll_power_down <= next_run[`RCCFG_BIT_PLL_DOWN];
      pll_bypass     <= next_run[`RCCFG_BIT_BYPASS];
      osc_source     <= {1'h0, next_run[`RCCFG_OSCSRC_HI:`RCCFG_OSCSRC_LO]};
    end
  end
endmodule : rccfg_top

// file: testbench.sv
// Self-checking bench for the run clock configuration register
`timescale 1ns/10ps
`include "rccfg_defines.svh"
module testbench;
  logic        pclk, pready, pslverr, pll_power_down, pll_bypass;
  logic        main_osc_disable, internal_osc_disable, use_system_divider;
  logic        presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, run_m, ext_m, d;
  logic [3:0]  pstrb = 4'h0;
  logic [2:0]  osc_source;
  logic [5:0]  system_divisor;
  logic [8:0]  pll_f;
  logic [4:0]  pll_r;
  int          fails, total_checks, seed, i;
  rccfg_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pll_power_down, .pll_bypass, .main_osc_disable,
    .internal_osc_disable, .osc_source, .system_divisor, .use_system_divider, .pll_f, .pll_r);
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd
  // Expected control outputs, override first
  function automatic logic [31:0] ctl_exp();
    if (ext_m[31])
      return {18'h0, ext_m[13], ext_m[11], run_m[1:0], run_m[22], ext_m[6:4], ext_m[28:23]};
    return {18'h0, run_m[13], run_m[11], run_m[1:0], run_m[22], 1'h0, run_m[5:4], 2'h0,
      run_m[26:23]};
  endfunction : ctl_exp
  // PLL output in kHz for crystal codes 4 and up lands within one percent of the target, and is zero for codes below 4
  task automatic chk_pll(input logic [3:0] code);
    int khz [16] = '{1000, 1843, 2000, 2458, 3580, 3686, 4000, 4096,
                     4915, 5000, 5120, 6000, 6144, 7373, 8000, 8192};
    int got;
    int exp;
    got = khz[code] * pll_f / (pll_r + 1);
    exp = code < 4'h4 ? 0 : `RCCFG_PLL_TARGET_MHZ * 1000;
    total_checks++;
    if ($isunknown({pll_f, pll_r}) || got < exp - exp / 100 || got > exp + exp / 100) begin
      fails++;
      $display("ERROR at %0t: pll got %h exp %h", $time, got, exp);
    end
  endtask : chk_pll
  // Outputs settle at the edge that closes the access that wrote them and are checked one edge later
  task automatic chk_ctl;
    @(posedge pclk);
    chk_rd({18'h0, pll_power_down, pll_bypass, internal_osc_disable, main_osc_disable,
      use_system_divider, osc_source, system_divisor}, ctl_exp());
    chk_pll(run_m[9:6]);
  endtask : chk_ctl
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    chk_rd({31'h0, pslverr}, {31'h0, a != 12'h060 && a != 12'h070 && (w || a != 12'h064)});
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      fails++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apb(1'h1, a, dd, s);
    if (a == 12'h060)
      run_m = run_m & ~(m & `RCCFG_RUN_WMASK) | dd & m & `RCCFG_RUN_WMASK;
    if (a == 12'h070)
      ext_m = ext_m & ~(m & `RCCFG_EXT_WMASK) | dd & m & `RCCFG_EXT_WMASK;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0, 4'h0);
    chk_rd(rd, exp);
  endtask : rdc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h8c6a;
    run_m = 32'h07803AD1;
    ext_m = 32'h07802810;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    chk_ctl();
    rdc(12'h060, run_m);
    rdc(12'h070, ext_m);
    rdc(12'h064, {18'h0, `RCCFG_PLL_F_RESET, `RCCFG_PLL_R_RESET});
    $display("reset test done");
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      if (i < 16)
        d[9:4] = {i[3:0], i[1:0]};
      else
        d[9] = 1'h1;
      if (i < 4)
        d[13:11] = 3'h7;
      wr(12'h060, d, i < 16 ? 4'hF : 4'($random(seed)));
      chk_ctl();
      rdc(12'h060, run_m);
    end
    $display("register test done");
    d = $random(seed);
    d[31] = 1'h1;
    wr(12'h070, d, 4'hF);
    chk_ctl();
    d = $random(seed);
    d[9] = 1'h1;
    wr(12'h060, d, 4'hF);
    chk_ctl();
    wr(12'h070, 32'h0, 4'hF);
    chk_ctl();
    $display("override test done");
    wr(12'h064, 32'hFFFFFFFF, 4'hF);
    wr(12'h100, 32'hFFFFFFFF, 4'hF);
    rdc(12'h100, 32'h0);
    rdc(12'h060, run_m);
    $display("error test done");
    summarize();
  end
endmodule : testbench
bind rccfg_top rccfg_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .pll_power_down, .pll_bypass,
  .main_osc_disable, .internal_osc_disable, .osc_source, .system_divisor);
